/* File: bench/npg_core_tb.sv */
// Self-checking bench for the pattern generator top.
// Assumes npg_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module npg_core_tb;
	import npg_pkg::*;

	logic clock;
	logic sys_rst;
	npg_bus_req_t bus_req;
	logic [31:0] rd_data;
	logic pat_clk;
	logic hold_initial_n;
	npg_word_t pat_out;
	int fail_count;
	int n_tests;
	int cycles;
	// Bit columns 7/0, 6/1 and 4/3 match, so a swap within those pairs goes unseen
	npg_word_t pat [4] = '{8'h3C, 8'hA1, 8'h5E, 8'hC7};

	npg_core u_npg_core (
		.clock(clock),
		.sys_rst(sys_rst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.pat_clk(pat_clk),
		.hold_initial_n(hold_initial_n),
		.pat_out(pat_out)
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk32(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk8(npg_word_t got, npg_word_t exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rd_chk(logic [3:0] a, logic [31:0] exp);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		chk32(rd_data, exp);
	endtask

	task automatic rd_get(logic [3:0] a, output logic [31:0] v);
		@(posedge clock);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		v = rd_data;
	endtask

	// One full pattern clock; output checked after the rise and the fall
	task automatic pulse(npg_word_t exp);
		@(posedge clock);
		pat_clk <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk8(pat_out, exp);
		@(posedge clock);
		pat_clk <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk8(pat_out, exp);
	endtask

	// Hold low, then release with room for the prefetch to refill
	task automatic hold_cycle(npg_word_t init);
		@(posedge clock);
		hold_initial_n <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk8(pat_out, init);
		pulse(init);
		@(posedge clock);
		hold_initial_n <= 1'b1;
		repeat (25) @(posedge clock);
	endtask

	task automatic t_reset;
		#1;
		chk8(pat_out, 8'h00);
		rd_chk(NPG_REG_CTRL, 32'h00005B00);
		rd_chk(NPG_REG_INIT, 32'h00000000);
		rd_chk(NPG_REG_STAT, 32'h00000000);
		rd_chk(NPG_REG_MADDR, 32'h00000000);
		rd_chk(4'hF, 32'h00000000);
	endtask

	task automatic t_load;
		wr_reg(NPG_REG_CTRL, 32'h00007F01);
		rd_chk(NPG_REG_CTRL, 32'h00005B01);
		wr_reg(NPG_REG_MADDR, 32'h0000007F);
		rd_chk(NPG_REG_MADDR, 32'h0000005B);
		wr_reg(NPG_REG_MADDR, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			wr_reg(NPG_REG_MDATA, {24'h000000, pat[i]});
		end
		rd_chk(NPG_REG_MDATA, 32'h00000000);
		rd_chk(NPG_REG_MADDR, 32'h00000004);
		wr_reg(NPG_REG_INIT, 32'h000000A5);
		rd_chk(NPG_REG_INIT, 32'h000000A5);
	endtask

	task automatic t_wrap;
		wr_reg(NPG_REG_CTRL, 32'h00000300);
		hold_cycle(8'hA5);
		pulse(pat[0]);
		for (int i = 1; i < 9; i++) begin
			pulse(pat[i % 4]);
		end
	endtask

	task automatic t_stop;
		wr_reg(NPG_REG_CTRL, 32'h00000301);
		hold_cycle(8'hA5);
		for (int i = 0; i < 4; i++) begin
			pulse(pat[i]);
		end
		for (int i = 0; i < 3; i++) begin
			pulse(pat[3]);
		end
		rd_chk(NPG_REG_STAT, {8'h00, pat[3], 8'h03, 8'h01});
		@(posedge clock);
		hold_initial_n <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk8(pat_out, 8'hA5);
		@(posedge clock);
		hold_initial_n <= 1'b1;
		repeat (25) @(posedge clock);
		pulse(pat[0]);
	endtask

	// Rise right after a restart finds the FIFO still empty
	task automatic t_ufl;
		logic [31:0] v;
		wr_reg(NPG_REG_CTRL, 32'h00000300);
		@(posedge clock);
		pat_clk <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk8(pat_out, pat[0]);
		@(posedge clock);
		pat_clk <= 1'b0;
		rd_get(NPG_REG_STAT, v);
		chk32(v & 32'h00000003, 32'h00000002);
		wr_reg(NPG_REG_STAT, 32'h00000002);
		rd_get(NPG_REG_STAT, v);
		chk32(v & 32'h00000003, 32'h00000000);
	endtask

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		sys_rst = 1'b1;
		bus_req = '0;
		pat_clk = 1'b0;
		hold_initial_n = 1'b1;
		fail_count = 0;
		n_tests = 0;
		cycles = 0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_load();
		t_wrap();
		t_stop();
		t_ufl();
		conclude();
	end
endmodule

/* File: rtl/npg_core.sv */
// Pattern generator top: pattern store, prefetch FIFO, output stage.
// Assumes pat_clk and hold_initial_n are synchronous to clock and that
// pat_clk stays at least one clock cycle in each level.
`timescale 1ns/1ps
module npg_core (
	input wire logic clock,
	input wire logic sys_rst,
	input wire npg_pkg::npg_bus_req_t bus_req,
	output logic [31:0] rd_data,
	input wire logic pat_clk,
	input wire logic hold_initial_n,
	output npg_pkg::npg_word_t pat_out
);
	import npg_pkg::*;

	typedef struct packed {
		logic hold_at_end_mode;
		npg_addr_t last;
		npg_word_t init;
		npg_addr_t maddr;
		npg_fetch_t fst;
		npg_addr_t faddr;
		npg_addr_t nidx;
		npg_addr_t pos;
		logic ended;
		logic started;
		logic ufl;
		logic clk_q;
		logic hold_q;
		logic flush;
		npg_word_t pat_out;
		logic [31:0] rd_data;
	} npg_core_st_t;

	npg_core_st_t r;
	npg_core_st_t n;

	npg_mem_wr_t mem_wr;
	npg_word_t mem_rdata;
	logic fifo_in_ready;
	logic fifo_out_valid;
	npg_word_t fifo_out_data;
	logic rise;
	logic pop;
	logic ufl_event;
	logic ctrl_wr;
	logic stat_wr;
	logic restart;

	assign rise = pat_clk && !r.clk_q;
	// Pops are blocked during a flush so stale words never reach the pins;
	// a rise in the restart cycle is dropped too, as its word is old
	assign pop = rise && hold_initial_n && !r.ended && !r.flush
		&& fifo_out_valid && !restart;
	assign ufl_event = rise && hold_initial_n && !r.ended && !r.flush
		&& !fifo_out_valid && !restart;
	assign ctrl_wr = bus_req.wr && (bus_req.addr == NPG_REG_CTRL);
	assign stat_wr = bus_req.wr && (bus_req.addr == NPG_REG_STAT);
	// A new configuration or a fresh hold restarts the prefetch from bit 0
	assign restart = ctrl_wr || (!hold_initial_n && r.hold_q);

	assign mem_wr = '{
		wr: bus_req.wr && (bus_req.addr == NPG_REG_MDATA),
		addr: r.maddr,
		data: bus_req.wdata[7:0]
	};

	always_comb begin
		n = r;
		n.clk_q = pat_clk;
		n.hold_q = hold_initial_n;
		n.flush = 1'b0;
		n.rd_data = '0;

		// Register writes
		if (bus_req.wr) begin
			case (bus_req.addr)
				NPG_REG_CTRL: begin
					n.hold_at_end_mode = bus_req.wdata[NPG_CTRL_MODE_BIT];
					n.last = npg_clamp(bus_req.wdata[NPG_CTRL_LAST_LSB +: 7]);
				end
				NPG_REG_INIT: begin
					n.init = bus_req.wdata[7:0];
				end
				NPG_REG_MADDR: begin
					n.maddr = npg_clamp(bus_req.wdata[6:0]);
				end
				NPG_REG_MDATA: begin
					n.maddr = npg_wrap_inc(r.maddr, NPG_LAST_MAX);
				end
				default: begin
				end
			endcase
		end

		// Register reads, data valid in the following cycle only
		if (bus_req.rd) begin
			case (bus_req.addr)
				NPG_REG_CTRL: begin
					n.rd_data[NPG_CTRL_MODE_BIT] = r.hold_at_end_mode;
					n.rd_data[NPG_CTRL_LAST_LSB +: 7] = r.last;
				end
				NPG_REG_INIT: begin
					n.rd_data[7:0] = r.init;
				end
				NPG_REG_MADDR: begin
					n.rd_data[6:0] = r.maddr;
				end
				NPG_REG_STAT: begin
					n.rd_data[NPG_STAT_END_BIT] = r.ended;
					n.rd_data[NPG_STAT_UFL_BIT] = r.ufl;
					n.rd_data[NPG_STAT_POS_LSB +: 7] = r.pos;
					n.rd_data[NPG_STAT_OUT_LSB +: 8] = r.pat_out;
				end
				default: begin
				end
			endcase
		end

		// Prefetch from the store into the FIFO
		unique case (r.fst)
			NPG_F_READ: begin
				n.fst = NPG_F_PUSH;
			end
			NPG_F_PUSH: begin
				if (fifo_in_ready) begin
					if (r.hold_at_end_mode && r.faddr == r.last) begin
						n.fst = NPG_F_DONE;
					end else begin
						n.faddr = npg_wrap_inc(r.faddr, r.last);
						n.fst = NPG_F_READ;
					end
				end
			end
			NPG_F_DONE: begin
			end
			default: begin
				n.fst = NPG_F_READ;
			end
		endcase

		// Output stage
		if (!hold_initial_n) begin
			n.pat_out = r.init;
			n.nidx = '0;
			n.ended = 1'b0;
			n.started = 1'b0;
		end else if (pop) begin
			n.pat_out = fifo_out_data;
			n.pos = r.nidx;
			n.nidx = npg_wrap_inc(r.nidx, r.last);
			n.ended = r.hold_at_end_mode && (r.nidx == r.last);
			n.started = 1'b1;
		end

		// Underflow is sticky; a new event beats a same-cycle clear
		if (stat_wr && bus_req.wdata[NPG_STAT_UFL_BIT]) begin
			n.ufl = 1'b0;
		end
		if (ufl_event) begin
			n.ufl = 1'b1;
		end

		if (restart) begin
			n.fst = NPG_F_READ;
			n.faddr = '0;
			n.nidx = '0;
			n.ended = 1'b0;
			n.started = 1'b0;
			n.flush = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
			r.hold_at_end_mode <= NPG_MODE_RST;
			r.last <= NPG_LAST_RST;
			r.init <= NPG_INIT_RST;
			r.pat_out <= NPG_INIT_RST;
			r.fst <= NPG_F_READ;
		end else begin
			r <= n;
		end
	end

	assign pat_out = r.pat_out;
	assign rd_data = r.rd_data;

	npg_mem u_mem (
		.clock(clock),
		.sys_rst(sys_rst),
		.wr(mem_wr),
		.rd_en(r.fst == NPG_F_READ),
		.rd_addr(r.faddr),
		.rd_data(mem_rdata)
	);

	// Eight words of slack absorb back-to-back pattern clock rises
	npg_fifo #(
		.WIDTH(NPG_OUTS),
		.DEPTH(NPG_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.flush(r.flush),
		.in_valid(r.fst == NPG_F_PUSH),
		.in_ready(fifo_in_ready),
		.in_data(mem_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	default clocking npg_cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	index_range_a: assert property (
		pop |-> (r.nidx <= r.last) && (r.last <= NPG_LAST_MAX)
	) else $error("pattern index beyond configured length");

	advance_one_a: assert property (
		pop |=> (pat_out == $past(fifo_out_data)) && (r.pos == $past(r.nidx))
	) else $error("rise did not advance exactly one pattern bit");

	init_on_hold_a: assert property (
		!hold_initial_n |=> pat_out == $past(r.init)
	) else $error("held output differs from initial value");

	drive_pattern_a: assert property (
		(rise && hold_initial_n && fifo_out_valid && !r.ended && !r.flush
		&& !restart) |=> r.started && (pat_out == $past(fifo_out_data))
	) else $error("pattern not driven while hold is released");

	wrap_restart_a: assert property (
		(pop && !r.hold_at_end_mode && r.nidx == r.last)
		|=> (r.nidx == 7'h00) && !r.ended
	) else $error("wrap mode did not restart after last bit");

	stop_keep_a: assert property (
		(r.ended && hold_initial_n && !restart)
		|=> r.ended && $stable(pat_out)
	) else $error("output moved after pattern end in hold-at-end mode");

	first_bit_a: assert property (
		(pop && !r.started) |-> r.nidx == 7'h00
	) else $error("first output after release is not bit zero");

	edge_only_a: assert property (
		($past(hold_initial_n) && pat_out != $past(pat_out)) |-> $past(rise)
	) else $error("output changed without a pattern clock rise");

	hold_rewind_a: assert property (
		!hold_initial_n |=> (r.nidx == 7'h00) && !r.ended && !r.started
	) else $error("hold did not rewind the pattern index");

	release_wait_a: assert property (
		(hold_initial_n && !rise) |=> $stable(pat_out)
	) else $error("output moved with no pattern clock rise");

	end_refuse_a: assert property (
		(rise && r.ended && hold_initial_n) |=> $stable(pat_out)
	) else $error("rise moved the output after pattern end");

	fetch_stop_a: assert property (
		(r.fst == NPG_F_DONE && !restart) |=> r.fst == NPG_F_DONE
	) else $error("prefetch resumed after the last bit");

	fetch_wrap_a: assert property (
		(r.fst == NPG_F_PUSH && fifo_in_ready && !r.hold_at_end_mode
		&& r.faddr == r.last && !restart) |=> r.faddr == 7'h00
	) else $error("prefetch did not wrap to the first word");

	flush_ignore_a: assert property (
		(rise && r.flush && hold_initial_n) |=> $stable(pat_out)
	) else $error("rise in a flush cycle moved the output");

	restart_ignore_a: assert property (
		(rise && restart && hold_initial_n) |=> $stable(pat_out)
	) else $error("rise during a restart moved the output");

	wrap_seen_c: cover property (
		pop && !r.hold_at_end_mode && r.nidx == r.last ##[1:200] pop
	);
	end_reached_c: cover property (
		pop && r.hold_at_end_mode && r.nidx == r.last ##1 r.ended [*3]
	);
	fifo_full_c: cover property (
		!fifo_in_ready && r.fst == NPG_F_PUSH
	);
	underflow_c: cover property (
		ufl_event
	);
	first_pop_c: cover property (
		pop && !r.started
	);
endmodule

/* File: rtl/npg_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides and flush.
// Assumes DEPTH is a power of two so pointers wrap naturally.
`timescale 1ns/1ps
module npg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import npg_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} npg_fifo_st_t;

	npg_fifo_st_t r;
	npg_fifo_st_t n;
	logic push;
	logic pop;

	assign in_ready = (r.cnt != CNT_FULL);
	assign out_valid = (r.cnt != '0);
	assign out_data = r.mem[r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_data;
			n.wp = PW'(r.wp + 1'b1);
		end
		if (pop) begin
			n.rp = PW'(r.rp + 1'b1);
		end
		if (push && !pop) begin
			n.cnt = (PW+1)'(r.cnt + 1'b1);
		end else if (pop && !push) begin
			n.cnt = (PW+1)'(r.cnt - 1'b1);
		end
		if (flush) begin
			n.wp = '0;
			n.rp = '0;
			n.cnt = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

/* File: rtl/npg_mem.sv */
// Pattern store: one word per pattern step, one bit per output.
// Assumes a single writer and a single reader; read data registered.
`timescale 1ns/1ps
module npg_mem (
	input wire logic clock,
	input wire logic sys_rst,
	input wire npg_pkg::npg_mem_wr_t wr,
	input wire logic rd_en,
	input wire npg_pkg::npg_addr_t rd_addr,
	output npg_pkg::npg_word_t rd_data
);
	import npg_pkg::*;

	typedef struct packed {
		logic [NPG_BITS-1:0][NPG_OUTS-1:0] cells;
		npg_word_t rdata;
	} npg_mem_st_t;

	npg_mem_st_t r;
	npg_mem_st_t n;

	always_comb begin
		n = r;
		if (wr.wr && wr.addr <= NPG_LAST_MAX) begin
			n.cells[wr.addr] = wr.data;
		end
		// Data held between reads so the fetcher may stall
		if (rd_en && rd_addr <= NPG_LAST_MAX) begin
			n.rdata = r.cells[rd_addr];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign rd_data = r.rdata;
endmodule

/* File: rtl/npg_pkg.sv */
// Shared constants, types and helpers of the pattern generator.
// Assumes one system clock; register port is the plain strobe port.
package npg_pkg;

	localparam int NPG_OUTS = 8;
	localparam int NPG_BITS = 92;
	localparam int NPG_FIFO_DEPTH = 8;

	// Register indices on the plain port
	localparam logic [3:0] NPG_REG_CTRL = 4'h0;
	localparam logic [3:0] NPG_REG_INIT = 4'h1;
	localparam logic [3:0] NPG_REG_MADDR = 4'h2;
	localparam logic [3:0] NPG_REG_MDATA = 4'h3;
	localparam logic [3:0] NPG_REG_STAT = 4'h4;

	// Field positions
	localparam int NPG_CTRL_MODE_BIT = 0;
	localparam int NPG_CTRL_LAST_LSB = 8;
	localparam int NPG_STAT_END_BIT = 0;
	localparam int NPG_STAT_UFL_BIT = 1;
	localparam int NPG_STAT_POS_LSB = 8;
	localparam int NPG_STAT_OUT_LSB = 16;

	// Reset values and limits
	localparam logic [6:0] NPG_LAST_MAX = 7'h5B;
	localparam logic [6:0] NPG_LAST_RST = 7'h5B;
	localparam logic [7:0] NPG_INIT_RST = 8'h00;
	localparam logic NPG_MODE_RST = 1'b0;

	typedef logic [7:0] npg_word_t;
	typedef logic [6:0] npg_addr_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} npg_bus_req_t;

	typedef struct packed {
		logic wr;
		npg_addr_t addr;
		npg_word_t data;
	} npg_mem_wr_t;

	typedef enum logic [1:0] {
		NPG_F_READ = 2'b00,
		NPG_F_PUSH = 2'b01,
		NPG_F_DONE = 2'b11
	} npg_fetch_t;

	function automatic npg_addr_t npg_wrap_inc(npg_addr_t a, npg_addr_t last);
		npg_addr_t r;
		r = (a >= last) ? 7'h00 : 7'(a + 7'h01);
		return r;
	endfunction

	function automatic npg_addr_t npg_clamp(npg_addr_t a);
		npg_addr_t r;
		r = (a > NPG_LAST_MAX) ? NPG_LAST_MAX : a;
		return r;
	endfunction

endpackage
